// >>> verilog/disk_cmd_pkg.sv
// Shared constants and carrier types for the disk command logic.
package disk_cmd_pkg;
	// Register word indices on the Avalon-MM slave.
	localparam logic [3:0] REG_STATUS    = 4'h0;
	localparam logic [3:0] REG_DEVICE    = 4'h1;
	localparam logic [3:0] REG_UNIT_FUNC = 4'h2;
	localparam logic [3:0] REG_MODIFIER  = 4'h3;
	localparam logic [3:0] REG_BUF_OFF   = 4'h4;
	localparam logic [3:0] REG_BUF_SEG   = 4'h5;
	localparam logic [3:0] REG_WAKEUP    = 4'h6;
	localparam logic [3:0] REG_START     = 4'h7;
	localparam logic [3:0] REG_GEOM_A    = 4'h8;
	localparam logic [3:0] REG_GEOM_B    = 4'h9;
	// Status register bit positions.
	localparam int ST_BUSY  = 0;
	localparam int ST_DONE  = 1;
	localparam int ST_ERROR = 2;
	localparam int ST_SEEK  = 3;
	localparam int ST_HARD  = 6;
	// Function codes and device classes.
	localparam logic [7:0]  FN_INIT     = 8'h00;
	localparam logic [7:0]  FN_STATUS   = 8'h01;
	localparam logic [7:0]  FN_DISK_MAX = 8'h0f;
	localparam logic [7:0]  FN_TAPE_LO  = 8'h80;
	localparam logic [7:0]  FN_TAPE_HI  = 8'h84;
	localparam logic [15:0] DEV_FIXED   = 16'h0000;
	localparam logic [15:0] DEV_FLOPPY  = 16'h0001;
	localparam logic [15:0] DEV_TAPE    = 16'h0010;
	localparam int MOD_NO_IRQ  = 0;
	localparam int WAKE_EXT_EN = 2;
	localparam logic [7:0]  ENC_MFM     = 8'h01;
	// Transfer lengths in bytes.
	localparam logic [3:0]  EXT_LEN      = 4'h8;
	localparam logic [3:0]  STAT_LEN     = 4'hc;
	localparam logic [3:0]  STAT_LEN_EXT = 4'hd;
	// Error status buffer byte positions.
	localparam int ESB_DCYL  = 3;
	localparam int ESB_DHEAD = 5;
	localparam int ESB_DSEC  = 6;
	localparam int ESB_ACYL  = 7;
	localparam int ESB_AHEAD = 9;
	localparam int ESB_ASEC  = 10;
	localparam int ESB_RETRY = 11;
	localparam int ESB_EXT   = 12;
	// Error codes raised by this block itself.
	localparam logic [7:0] ERC_SEEK_BUSY  = 8'h16;
	localparam logic [7:0] ERC_BAD_FORMAT = 8'h17;
	localparam logic [7:0] ERC_BAD_SECLEN = 8'h21;
	localparam logic [7:0] ERC_BAD_CMD    = 8'h24;
	localparam logic [7:0] ERC_NOT_READY  = 8'h27;
	localparam logic       RST_WAITREQ    = 1'b1;
	localparam int         DRIVE_IDX_W    = 3;

	typedef struct packed {
		logic [15:0] cyl;
		logic [7:0]  head;
		logic [7:0]  sector;
	} pos_type;

	typedef struct packed {
		logic        valid;
		logic        floppy;
		logic [15:0] cyl;
		logic [7:0]  fixed_heads;
		logic [7:0]  remov_heads;
		logic [7:0]  spt;
		logic [15:0] seclen;
		logic [7:0]  alt_enc;
	} drive_param_type;

	typedef struct packed {
		logic       go;
		logic       write;
		logic [3:0] idx;
		logic [7:0] wdata;
	} mem_cmd_type;
endpackage

// >>> verilog/drive_table.sv
// Per-drive parameter store filled by the initialize command.
`timescale 1ns/10ps
module drive_table
#(
	parameter int NUM_DRIVES = 8,
	parameter int IDX_W      = 3
)
(
	input  wire logic                         clk,
	input  wire logic                         nrst,
	input  wire logic                         ce,
	input  wire logic                         wr_en,
	input  wire logic [IDX_W-1:0]             wr_idx,
	input  disk_cmd_pkg::drive_param_type     wr_data,
	input  wire logic [IDX_W-1:0]             rd_idx,
	output disk_cmd_pkg::drive_param_type     rd_data
);
	import disk_cmd_pkg::*;

	typedef struct packed {
		drive_param_type [NUM_DRIVES-1:0] ent;
	} table_state_type;

	table_state_type s;
	table_state_type next_s;
	drive_param_type next_ent [NUM_DRIVES];

	// Each entry loads only when it is addressed.
	for (genvar i = 0; i < NUM_DRIVES; i++)
	begin : g_ent
		assign next_ent[i] = (wr_en && wr_idx == IDX_W'(i)) ? wr_data
			: s.ent[i];
	end

	// Gather the entries into the next state.
	always_comb
	begin
		next_s = s;
		for (int i = 0; i < NUM_DRIVES; i++)
		begin
			next_s.ent[i] = next_ent[i];
		end
	end

	// A reset leaves every drive uninitialised.
	always_ff @(posedge clk)
	begin
		if (!nrst)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign rd_data = s.ent[rd_idx];
endmodule

// >>> verilog/host_mem_port.sv
// Single-byte host memory master with segmented addressing.
`timescale 1ns/10ps
module host_mem_port
(
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic                 ce,
	input  disk_cmd_pkg::mem_cmd_type cmd,
	input  wire logic [15:0]          base_off,
	input  wire logic [15:0]          base_seg,
	output logic                      mem_req,
	output logic                      mem_we,
	output logic [19:0]               mem_addr,
	output logic [7:0]                mem_wdata,
	input  wire logic [7:0]           mem_rdata,
	input  wire logic                 mem_ack,
	output logic                      done,
	output logic [7:0]                rdata
);
	import disk_cmd_pkg::*;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [19:0] addr;
		logic [7:0]  wdata;
		logic        done;
		logic [7:0]  rdata;
	} port_state_type;

	port_state_type s;
	port_state_type next_s;

	// Request stands until acknowledged; a new command is taken only idle.
	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		if (s.req)
		begin
			if (mem_ack)
			begin
				next_s.req = 1'b0;
				next_s.done = 1'b1;
				next_s.rdata = mem_rdata;
			end
		end
		else if (cmd.go)
		begin
			next_s.req = 1'b1;
			next_s.we = cmd.write;
			next_s.wdata = cmd.wdata;
			next_s.addr = {base_seg, 4'h0} + {4'h0, base_off}
				+ {16'h0, cmd.idx};
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign mem_req = s.req;
	assign mem_we = s.we;
	assign mem_addr = s.addr;
	assign mem_wdata = s.wdata;
	assign done = s.done;
	assign rdata = s.rdata;
endmodule

// >>> verilog/disk_init_status.sv
// Initialize and transfer-status command logic with error status buffer.
// Summary of operation
// R01: Initialize stores drive parameters and seeks that drive to cylinder 0.
// R02: Initialize fetches eight extension bytes at buffer offset and segment.
// R03: Commands to uninitialised drives are refused and report an error.
// R04: Host should initialize every drive after each reset.
// R05: Zero cylinder count takes the drive out of service.
// R06: Extension: cylinders, fixed, removable, sectors, length, alt/encoding.
// R07: Host supplies sector length 128, 256, 512 or 1024 matching media.
// R08: Floppy byte 7 is encoding FM/MFM; fixed disk byte 7 alternates.
// R09: Transfer status writes the error buffer to host memory.
// R10: Every non-status command clears the error buffer.
// R11: Status is 13 bytes with extended enable, otherwise 12.
// R12: Buffer layout: hard, soft, desired, actual with flags, retries, code.
// R13: Byte 0 bits 3-7: RAM, ROM, seek busy, bad format, end of media.
// R14: Bad format on both track marks or unassigned alternate access.
// R15: Byte 1 bits: sector size through write protect, in order.
// R16: ID sector length differing from initialised length flags size error.
// R17: Byte 2 bits 3-7: data ECC, ID ECC, fault, cylinder, seek error.
// R18: Status bit 6 shows a hard, uncorrectable ECC error.
// R19: Device word 0000 fixed disk, 0001 floppy, 0010 tape.
// R20: Modifier bit 0 suppresses the completion interrupt.
// R21: Only one error is recorded per command.
`timescale 1ns/10ps
module disk_init_status
(
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic                 ce,
	input  wire logic [3:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	output logic [31:0]               avs_readdata,
	output logic                      avs_waitrequest,
	output logic                      mem_req,
	output logic                      mem_we,
	output logic [19:0]               mem_addr,
	output logic [7:0]                mem_wdata,
	input  wire logic [7:0]           mem_rdata,
	input  wire logic                 mem_ack,
	output logic                      seek_req,
	output logic [2:0]                seek_unit,
	input  wire logic                 seek_done,
	output logic                      ext_go,
	output logic [7:0]                ext_func,
	input  wire logic                 ext_done,
	input  wire logic                 err_strobe,
	input  wire logic [7:0]           err_code,
	input  wire logic                 err_hard,
	input  disk_cmd_pkg::pos_type     err_desired,
	input  disk_cmd_pkg::pos_type     err_actual,
	input  wire logic [3:0]           err_flags,
	input  wire logic [7:0]           err_retries,
	input  wire logic                 id_strobe,
	input  wire logic [15:0]          id_seclen,
	input  wire logic                 fmt_check,
	input  wire logic                 fmt_alt_mark,
	input  wire logic                 fmt_defect_mark,
	input  wire logic                 alt_unassigned,
	output logic                      sel_mfm,
	output logic [7:0]                sel_alt_cyl,
	output logic                      cmd_irq
);
	import disk_cmd_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_FETCH  = 3'b001,
		S_SEEK   = 3'b011,
		S_FINISH = 3'b010,
		S_XFER   = 3'b110,
		S_EXT    = 3'b100
	} fsm_type;

	typedef struct packed {
		fsm_type          fsm;
		logic             waitreq;
		logic [31:0]      readdata;
		logic [15:0]      device;
		logic [7:0]       unit;
		logic [7:0]       func;
		logic [15:0]      modifier;
		logic [15:0]      buf_off;
		logic [15:0]      buf_seg;
		logic [7:0]       wakeup;
		logic [7:0][7:0]  ext_bytes;
		logic [12:0][7:0] esb;
		logic [3:0]       idx;
		logic [3:0]       xfer_count;
		logic             err_taken;
		logic             busy;
		logic             done;
		logic             err_flag;
		logic             hard_ecc;
		mem_cmd_type      mem_cmd;
		logic             tbl_wr;
		logic             seek_req;
		logic [2:0]       seek_unit;
		logic             ext_go;
		logic             cmd_irq;
		logic             sel_mfm;
		logic [7:0]       sel_alt_cyl;
	} main_state_type;

	main_state_type  s;
	main_state_type  next_s;
	drive_param_type tbl_sel;
	drive_param_type tbl_new;
	logic [2:0]      drive_idx;
	logic            mem_done;
	logic [7:0]      mem_byte;
	logic            is_tape;
	logic [3:0]      stat_len;

	// Maps a code onto {in-table, byte, bit}; others go to the code byte.
	function automatic logic [5:0] err_slot(input logic [7:0] c);
		logic [3:0] hi;
		logic [3:0] lo;
		logic       ok;
		hi = c[7:4];
		lo = c[3:0];
		ok = (hi >= 4'h1) && (hi <= 4'h3) && (lo <= 4'h8)
			&& (lo >= ((hi == 4'h2) ? 4'h1 : 4'h4));
		err_slot = {ok, 2'(hi - 4'h1), 3'(lo - 4'h1)};
	endfunction

	// Drives are indexed by class and low unit bits.
	assign is_tape = (s.device == DEV_TAPE);
	assign drive_idx = {s.device == DEV_FLOPPY, s.unit[1:0]}; // see R19
	assign stat_len = s.wakeup[WAKE_EXT_EN] ? STAT_LEN_EXT
		: STAT_LEN; // see R11

	// Extension bytes in fixed order, low byte first in words.
	assign tbl_new = '{
		valid:       {s.ext_bytes[1], s.ext_bytes[0]} != 16'h0000,
		floppy:      s.device == DEV_FLOPPY,
		cyl:         {s.ext_bytes[1], s.ext_bytes[0]},
		fixed_heads: s.ext_bytes[2],
		remov_heads: s.ext_bytes[3],
		spt:         s.ext_bytes[4],
		seclen:      {s.ext_bytes[6], s.ext_bytes[5]},
		alt_enc:     s.ext_bytes[7]
	}; // see R05 see R06

	drive_table #(
		.NUM_DRIVES (8),
		.IDX_W      (DRIVE_IDX_W)
	) u_table (
		.clk     (clk),
		.nrst    (nrst),
		.ce      (ce),
		.wr_en   (s.tbl_wr),
		.wr_idx  (drive_idx),
		.wr_data (tbl_new),
		.rd_idx  (drive_idx),
		.rd_data (tbl_sel)
	);

	host_mem_port u_mem (
		.clk       (clk),
		.nrst      (nrst),
		.ce        (ce),
		.cmd       (s.mem_cmd),
		.base_off  (s.buf_off),
		.base_seg  (s.buf_seg),
		.mem_req   (mem_req),
		.mem_we    (mem_we),
		.mem_addr  (mem_addr),
		.mem_wdata (mem_wdata),
		.mem_rdata (mem_rdata),
		.mem_ack   (mem_ack),
		.done      (mem_done),
		.rdata     (mem_byte)
	);

	// Bus slave, command sequencer and error capture in one next-state step.
	always_comb
	begin
		logic       ev;
		logic [7:0] evc;
		logic       start;
		logic [5:0] slot;
		ev = 1'b0;
		evc = 8'h00;
		start = 1'b0;
		slot = 6'h00;
		next_s = s;
		next_s.mem_cmd.go = 1'b0;
		next_s.tbl_wr = 1'b0;
		next_s.seek_req = 1'b0;
		next_s.ext_go = 1'b0;
		next_s.cmd_irq = 1'b0;
		next_s.sel_mfm = tbl_sel.floppy && tbl_sel.alt_enc == ENC_MFM; // see R08
		next_s.sel_alt_cyl = tbl_sel.floppy ? 8'h00 : tbl_sel.alt_enc;

		// One wait cycle, then the answer; registers load on the free edge.
		next_s.waitreq = !((avs_read || avs_write) && s.waitreq);
		if ((avs_read || avs_write) && s.waitreq)
		begin
			next_s.readdata = 32'h0;
			unique case (avs_address)
				REG_STATUS:
				begin
					next_s.readdata[ST_BUSY] = s.busy;
					next_s.readdata[ST_DONE] = s.done;
					next_s.readdata[ST_ERROR] = s.err_flag;
					next_s.readdata[ST_SEEK] = s.fsm == S_SEEK;
					next_s.readdata[ST_HARD] = s.hard_ecc; // see R18
				end
				REG_DEVICE:    next_s.readdata[15:0] = s.device;
				REG_UNIT_FUNC: next_s.readdata[15:0] = {s.func, s.unit};
				REG_MODIFIER:  next_s.readdata[15:0] = s.modifier;
				REG_BUF_OFF:   next_s.readdata[15:0] = s.buf_off;
				REG_BUF_SEG:   next_s.readdata[15:0] = s.buf_seg;
				REG_WAKEUP:    next_s.readdata[7:0] = s.wakeup;
				REG_START:     next_s.readdata[3:0] = s.xfer_count;
				REG_GEOM_A:    next_s.readdata = {tbl_sel.seclen, tbl_sel.cyl};
				REG_GEOM_B:    next_s.readdata = {tbl_sel.alt_enc,
					tbl_sel.spt, tbl_sel.remov_heads, tbl_sel.fixed_heads};
				default:       next_s.readdata = 32'h0;
			endcase
		end

		// Command fields other than wakeup are frozen while a command runs.
		if (avs_write && !s.waitreq)
		begin
			if (avs_address == REG_WAKEUP)
				next_s.wakeup = avs_writedata[7:0];
			else if (avs_address == REG_START)
			begin
				if (s.fsm == S_SEEK)
				begin
					ev = 1'b1; // see R13
					evc = ERC_SEEK_BUSY;
				end
				start = !s.busy;
			end
			else if (!s.busy)
			begin
				unique case (avs_address)
					REG_DEVICE:    next_s.device = avs_writedata[15:0];
					REG_UNIT_FUNC: {next_s.func, next_s.unit}
						= avs_writedata[15:0];
					REG_MODIFIER:  next_s.modifier = avs_writedata[15:0];
					REG_BUF_OFF:   next_s.buf_off = avs_writedata[15:0];
					REG_BUF_SEG:   next_s.buf_seg = avs_writedata[15:0];
					default:       next_s.wakeup = s.wakeup;
				endcase
			end
		end

		// Dispatch a new command; the status command keeps the buffer.
		if (start)
		begin
			next_s.busy = 1'b1;
			next_s.done = 1'b0;
			next_s.err_flag = 1'b0;
			next_s.idx = 4'h0;
			next_s.seek_unit = drive_idx;
			if (s.func != FN_STATUS)
			begin
				next_s.esb = '0; // see R10
				next_s.err_taken = 1'b0;
				next_s.hard_ecc = 1'b0;
			end
			if (s.func == FN_INIT && !is_tape)
			begin
				next_s.fsm = S_FETCH;
				next_s.mem_cmd = '{go: 1'b1, write: 1'b0,
					idx: 4'h0, wdata: 8'h00}; // see R02
			end
			else if (s.func == FN_STATUS)
			begin
				next_s.fsm = S_XFER;
				next_s.mem_cmd = '{go: 1'b1, write: 1'b1,
					idx: 4'h0, wdata: s.esb[0]}; // see R09
			end
			else if (s.func > FN_DISK_MAX
				&& (s.func < FN_TAPE_LO || s.func > FN_TAPE_HI))
			begin
				next_s.fsm = S_FINISH;
				ev = 1'b1;
				evc = ERC_BAD_CMD;
			end
			else if (!is_tape && !tbl_sel.valid)
			begin
				next_s.fsm = S_FINISH; // see R03
				ev = 1'b1;
				evc = ERC_NOT_READY;
			end
			else
			begin
				next_s.fsm = S_EXT;
				next_s.ext_go = 1'b1;
			end
		end

		unique case (s.fsm)
			S_IDLE:
				next_s.busy = next_s.busy;
			S_FETCH:
				if (mem_done)
				begin
					next_s.ext_bytes[s.idx[2:0]] = mem_byte;
					if (s.idx == EXT_LEN - 4'h1)
					begin
						next_s.tbl_wr = 1'b1; // see R01
						if ({s.ext_bytes[1], s.ext_bytes[0]} != 16'h0000)
						begin
							next_s.fsm = S_SEEK; // see R01
							next_s.seek_req = 1'b1;
						end
						else
							next_s.fsm = S_FINISH; // see R05
					end
					else
					begin
						next_s.idx = s.idx + 4'h1;
						next_s.mem_cmd = '{go: 1'b1, write: 1'b0,
							idx: s.idx + 4'h1, wdata: 8'h00};
					end
				end
			S_SEEK:
				if (seek_done)
					next_s.fsm = S_FINISH;
			S_XFER:
				if (mem_done)
				begin
					if (s.idx == stat_len - 4'h1)
					begin
						next_s.fsm = S_FINISH;
						next_s.xfer_count = stat_len; // see R11
					end
					else
					begin
						next_s.idx = s.idx + 4'h1;
						next_s.mem_cmd = '{go: 1'b1, write: 1'b1,
							idx: s.idx + 4'h1, wdata: s.esb[s.idx + 4'h1]};
					end
				end
			S_EXT:
				if (ext_done)
					next_s.fsm = S_FINISH;
			S_FINISH:
			begin
				next_s.fsm = S_IDLE;
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
				next_s.err_flag = s.err_taken;
				next_s.cmd_irq = !s.modifier[MOD_NO_IRQ]; // see R20
			end
		endcase

		// Drive-side checks; block-raised errors take priority.
		if (!ev && id_strobe && id_seclen != tbl_sel.seclen)
		begin
			ev = 1'b1; // see R16
			evc = ERC_BAD_SECLEN;
		end
		else if (!ev && ((fmt_check && fmt_alt_mark && fmt_defect_mark)
			|| alt_unassigned))
		begin
			ev = 1'b1; // see R14
			evc = ERC_BAD_FORMAT;
		end
		else if (!ev && err_strobe)
		begin
			ev = 1'b1;
			evc = err_code;
		end

		// Applied after the clear above, so a same-cycle error survives.
		if (ev && !next_s.err_taken)
		begin
			next_s.err_taken = 1'b1; // see R21
			slot = err_slot(evc);
			if (slot[5])
				next_s.esb[slot[4:3]][slot[2:0]] = 1'b1; // see R13 see R15 see R17
			else
				next_s.esb[ESB_EXT] = evc; // see R12
			if (err_strobe && evc == err_code)
			begin
				next_s.hard_ecc = err_hard; // see R18
				{next_s.esb[ESB_DCYL + 1], next_s.esb[ESB_DCYL]}
					= err_desired.cyl;
				next_s.esb[ESB_DHEAD] = err_desired.head;
				next_s.esb[ESB_DSEC] = err_desired.sector;
				next_s.esb[ESB_ACYL] = err_actual.cyl[7:0];
				next_s.esb[ESB_ACYL + 1] = {err_flags,
					err_actual.cyl[11:8]}; // see R12
				next_s.esb[ESB_AHEAD] = err_actual.head;
				next_s.esb[ESB_ASEC] = err_actual.sector;
				next_s.esb[ESB_RETRY] = err_retries;
			end
		end
	end

	// Synchronous reset; the clock enable freezes everything.
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			s <= '0;
			s.waitreq <= RST_WAITREQ;
		end
		else if (ce)
			s <= next_s;
	end

	assign avs_readdata = s.readdata;
	assign avs_waitrequest = s.waitreq;
	assign seek_req = s.seek_req;
	assign seek_unit = s.seek_unit;
	assign ext_go = s.ext_go;
	assign ext_func = s.func;
	assign sel_mfm = s.sel_mfm;
	assign sel_alt_cyl = s.sel_alt_cyl;
	assign cmd_irq = s.cmd_irq;
endmodule

// >>> tb/disk_chk_chk.sv
// Protocol and rule checker bound to the disk command block.
`timescale 1ns/10ps
module disk_chk
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [19:0] mem_addr,
	input wire logic [7:0]  mem_wdata,
	input wire logic        mem_ack,
	input wire logic        seek_req,
	input wire logic        ext_go,
	input wire logic        sel_mfm,
	input wire logic [7:0]  sel_alt_cyl,
	input wire logic        cmd_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Bus answers last one cycle and come one cycle after the request.
	property p_wait_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("waitrequest low for more than one cycle");
	property p_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer)
		else $error("bus request not answered in one cycle");
	// Strobes towards the drive side and the host are single pulses.
	property p_seek_pulse;
		seek_req |=> !seek_req;
	endproperty
	a_seek_pulse: assert property (p_seek_pulse)
		else $error("seek request longer than one cycle");
	property p_irq_pulse;
		cmd_irq |=> !cmd_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("completion interrupt longer than one cycle");
	property p_ext_pulse;
		ext_go |=> !ext_go;
	endproperty
	a_ext_pulse: assert property (p_ext_pulse)
		else $error("command start longer than one cycle");
	// A memory request must not move before the host takes it.
	property p_mem_hold;
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
			&& $stable(mem_we) && $stable(mem_wdata);
	endproperty
	a_mem_hold: assert property (p_mem_hold)
		else $error("memory request changed before acknowledge");
	property p_mem_drop;
		mem_req && mem_ack |=> !mem_req;
	endproperty
	a_mem_drop: assert property (p_mem_drop)
		else $error("memory request held after acknowledge");
	// A floppy has an encoding, never alternate cylinders.
	property p_floppy_alt;
		sel_mfm |-> sel_alt_cyl == 8'h00;
	endproperty
	a_floppy_alt: assert property (p_floppy_alt)
		else $error("alternate cylinders shown for a floppy");

	c_seek: cover property (seek_req);
	c_mem_wr: cover property (mem_req && mem_we && mem_ack);
	c_ext: cover property (ext_go);
	c_mfm: cover property (sel_mfm);
endmodule

bind disk_init_status disk_chk chk_u
(
	.clk            (clk),
	.nrst           (nrst),
	.avs_read       (avs_read),
	.avs_write      (avs_write),
	.avs_waitrequest(avs_waitrequest),
	.mem_req        (mem_req),
	.mem_we         (mem_we),
	.mem_addr       (mem_addr),
	.mem_wdata      (mem_wdata),
	.mem_ack        (mem_ack),
	.seek_req       (seek_req),
	.ext_go         (ext_go),
	.sel_mfm        (sel_mfm),
	.sel_alt_cyl    (sel_alt_cyl),
	.cmd_irq        (cmd_irq)
);

// >>> tb/host_mem_model.sv
// Host memory holding parameter extensions and status buffers.
`timescale 1ns/10ps
module host_mem_model
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [1:0]  dly,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [19:0] mem_addr,
	input wire logic [7:0]  mem_wdata,
	output logic [7:0]      mem_rdata,
	output logic            mem_ack
);
	logic [7:0] mem [0:255];
	logic [1:0] cnt;

	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'h00;
		mem_rdata = 8'h00;
		mem_ack = 1'b0;
		cnt = 2'h0;
	end

	// Answers after dly waits; read data toggle when not valid.
	always @(posedge clk)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (!nrst)
			cnt <= 2'h0;
		else if (mem_req && !mem_ack)
		begin
			if (cnt == dly)
			begin
				mem_ack <= 1'b1;
				cnt <= 2'h0;
				if (mem_we)
					mem[mem_addr[7:0]] <= mem_wdata;
				else
					mem_rdata <= mem[mem_addr[7:0]];
			end
			else
				cnt <= cnt + 2'h1;
		end
	end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the initialize and status commands.
`timescale 1ns/10ps
module testbench;
	import disk_cmd_pkg::*;
	logic        clk = 0, nrst = 0, ce = 1;
	logic [3:0]  avs_address = 0;
	logic        avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [31:0] avs_writedata = 0, avs_readdata, q, st;
	logic        mem_req, mem_we, mem_ack, seek_req, seek_done = 0;
	logic [19:0] mem_addr;
	logic [7:0]  mem_wdata, mem_rdata, ext_func, err_code = 0;
	logic [7:0]  err_retries = 0, sel_alt_cyl;
	logic [2:0]  seek_unit, sunit = 0;
	logic        ext_go, ext_done = 0, err_strobe = 0, err_hard = 0;
	logic        id_strobe = 0, fmt_check = 0, fmt_alt_mark = 0;
	logic        fmt_defect_mark = 0, alt_unassigned = 0, sel_mfm, cmd_irq;
	pos_type     err_desired = 0, err_actual = 0;
	logic [3:0]  err_flags = 0;
	logic [15:0] id_seclen = 0;
	logic [1:0]  dly = 0;
	int          failures = 0, checked = 0, seeks = 0, irqs = 0, kind = 0;
	int          n0, i0;
	logic [63:0] fl = 64'h0101000f02000050, fx = 64'h050100001f040100;
	logic [7:0]  efunc = 0;

	always #2 clk = ~clk;

	disk_init_status dut_u (.*);
	host_mem_model host_u (.*);

	// Far side of the drive: answers seeks and ends commands.
	always @(posedge clk)
	begin
		seek_done <= seek_req;
		fmt_check <= ext_go && kind == 1;
		id_strobe <= ext_go && kind == 2;
		err_strobe <= ext_go && kind == 3;
		alt_unassigned <= ext_go && kind == 4;
		ext_done <= (ext_go && kind == 0) || fmt_check || id_strobe
			|| err_strobe || alt_unassigned;
		if (seek_req)
		begin
			seeks <= seeks + 1;
			sunit <= seek_unit;
		end
		if (cmd_irq)
			irqs <= irqs + 1;
		if (ext_go)
			efunc <= ext_func;
	end

	task end_sim;
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One Avalon access; a spare edge leaves one idle cycle between accesses.
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	task run_cmd(input logic [15:0] dev, input logic [7:0] unit,
		input logic [7:0] func, input logic m, input logic [15:0] off);
		int n;
		bus(1, REG_DEVICE, {16'h0, dev});
		bus(1, REG_UNIT_FUNC, {16'h0, func, unit});
		bus(1, REG_MODIFIER, {31'h0, m});
		bus(1, REG_BUF_OFF, {16'h0, off});
		bus(1, REG_BUF_SEG, 32'h0);
		bus(1, REG_START, 32'h1);
		n = 0;
		do
		begin
			bus(0, REG_STATUS, 0);
			n++;
		end
		while (q[ST_BUSY] !== 1'b0 && n < 300);
		st = q;
		chk("idle", 0, st[ST_BUSY]);
	endtask

	// Runs a command, then fetches the error buffer and checks it.
	task do_case(input logic [15:0] dev, input logic [7:0] unit,
		input logic [7:0] func, input int k, input int ei,
		input logic [7:0] ev, input logic [2:0] wake);
		kind = k;
		i0 = irqs;
		run_cmd(dev, unit, func, 0, 16'h0);
		chk("irq", i0 + 1, irqs);
		chk("err", {k == 3, ev != 0}, {st[ST_HARD], st[ST_ERROR]});
		kind = 0;
		for (int i = 0; i < 16; i++)
			host_u.mem[8'h40 + i] = 8'hee;
		bus(1, REG_WAKEUP, {29'h0, wake});
		run_cmd(DEV_FIXED, 0, FN_STATUS, 0, 16'h0040);
		bus(0, REG_START, 0);
		chk("count", wake[2] ? 13 : 12, q);
		chk("tail", 8'hee, host_u.mem[wake[2] ? 8'h4d : 8'h4c]);
		for (int i = 0; i < 3; i++)
			chk("esb", i == ei ? ev : 8'h0, host_u.mem[8'h40 + i]);
		chk("retry", k == 3 ? 8'h05 : 8'h0, host_u.mem[8'h4b]);
		chk("pos", k == 3 ? 32'hb307_0504 : 0,
			{host_u.mem[8'h48], host_u.mem[8'h47], host_u.mem[8'h46],
			host_u.mem[8'h45]});
	endtask

	initial
	begin
		repeat (60000) @(posedge clk);
		failures++;
		end_sim;
	end

	initial
	begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		bus(0, REG_STATUS, 0);
		chk("rst_status", 0, q);
		bus(1, 4'hf, 32'hffff_ffff);
		bus(0, 4'hf, 0);
		chk("unmapped", 0, q);
		do_case(DEV_FIXED, 0, 8'h02, 0, 1, 8'h40, 3'h4);
		// Floppy unit 1: 80 cylinders, 2 heads, 15 sectors, 256, MFM.
		for (int i = 0; i < 8; i++)
		begin
			host_u.mem[8'h10 + i] = fl[8 * i +: 8];
			host_u.mem[8'h30 + i] = fx[8 * i +: 8];
		end
		dly <= 2;
		n0 = seeks;
		i0 = irqs;
		run_cmd(DEV_FLOPPY, 1, FN_INIT, 1, 16'h0010);
		chk("seek", n0 + 1, seeks);
		chk("unit", 3'b101, sunit);
		chk("no_irq", i0, irqs);
		bus(0, REG_GEOM_A, 0);
		chk("geom_a", 32'h0100_0050, q);
		bus(0, REG_GEOM_B, 0);
		chk("geom_b", 32'h010f_0200, q);
		chk("mfm", 1, sel_mfm);
		run_cmd(DEV_FIXED, 2, FN_INIT, 0, 16'h0030);
		chk("alt", 8'h05, sel_alt_cyl);
		chk("fm", 0, sel_mfm);
		chk("unit_fixed", 3'b010, sunit);
		// A zero cylinder count must retire a drive that was in service.
		run_cmd(DEV_FIXED, 2, FN_INIT, 0, 16'h0020);
		chk("no_seek", n0 + 2, seeks);
		do_case(DEV_FIXED, 2, 8'h02, 0, 1, 8'h40, 0);
		dly <= 3;
		err_desired <= '{16'h0123, 8'h04, 8'h05};
		err_actual <= '{16'h0307, 8'h09, 8'h0a};
		err_flags <= 4'hb;
		fmt_alt_mark <= 1'b1;
		fmt_defect_mark <= 1'b1;
		id_seclen <= 16'h0200;
		err_code <= 8'h34;
		err_hard <= 1'b1;
		err_retries <= 8'h05;
		for (int k = 1; k < 5; k++)
			do_case(DEV_FLOPPY, 1, 8'h02, k, k == 2 ? 1 : k == 3 ? 2 : 0,
				k == 2 ? 8'h01 : k == 3 ? 8'h08 : 8'h40, 0);
		do_case(DEV_FLOPPY, 1, 8'h02, 0, 0, 8'h0, 0);
		do_case(DEV_FLOPPY, 1, 8'h30, 0, 1, 8'h08, 0);
		do_case(DEV_TAPE, 0, FN_TAPE_LO, 0, 0, 8'h0, 0);
		chk("ext_func", FN_TAPE_LO, efunc);
		// A second reset must leave floppy unit 1 uninitialised again.
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		do_case(DEV_FLOPPY, 1, 8'h02, 0, 1, 8'h40, 0);
		end_sim;
	end
endmodule
